// ---- hw/lcr_regs.sv ----
// APB register bank for conversion mode, lead-off and central terminal control.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module lcr_regs #(
  parameter int CHANNELS = lcr_pkg::CHANNELS_DEFAULT
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output lcr_pkg::lcr_cfg_out_t      cfg_out,
  output lcr_pkg::lcr_ctl_out_t      ctl_out
);

  logic [7:0]          cfg;
  logic [7:0]          next_cfg;
  logic [7:0]          ctl;
  logic [7:0]          next_ctl;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  lcr_pkg::lcr_state_t state;
  lcr_pkg::lcr_state_t next_state;
  lcr_pkg::lcr_cfg_out_t next_cfg_out;
  logic [4:0]          next_routes;
  logic [4:0]          routes;
  logic [7:0]          amp_a_onehot;

  logic hit_cfg;
  logic hit_ctl;
  logic setup;

  // Address decode is a full compare, so any other word, aliases included,
  // is answered with an error.
  assign hit_cfg = (paddr == lcr_pkg::CFG_OFFSET);
  assign hit_ctl = (paddr == lcr_pkg::CTL_OFFSET);
  assign setup   = psel && !penable;

  // The answer is given one cycle after the setup, so every access has two
  // cycles; pready stays low in the setup cycle.
  always_comb begin
    next_state   = state;
    next_cfg     = cfg;
    next_ctl     = ctl;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      lcr_pkg::LCR_IDLE: begin
        if (setup) begin
          next_state   = lcr_pkg::LCR_ACCESS;
          next_pready  = 1'b1;
          next_pslverr = !(hit_cfg || hit_ctl);
          next_prdata  = 32'h0000_0000;
          if (!pwrite && hit_cfg) begin
            next_prdata = {24'h00_0000, cfg};
          end else if (!pwrite && hit_ctl) begin
            next_prdata = {24'h00_0000, ctl};
          end
        end
      end
      lcr_pkg::LCR_ACCESS: begin
        next_state = lcr_pkg::LCR_IDLE;
        if (psel && penable && pwrite && pstrb[0]) begin
          if (hit_cfg) begin
            // Only the low nibble is held here; upper bits read as zero.
            next_cfg = pwdata[7:0] & lcr_pkg::CFG_WMASK;
          end
          if (hit_ctl) begin
            next_ctl = pwdata[7:0];
          end
        end
      end
      default: begin
        next_state = lcr_pkg::LCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= lcr_pkg::LCR_IDLE;
      cfg     <= lcr_pkg::CFG_RESET;
      ctl     <= lcr_pkg::CTL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state   <= next_state;
      cfg     <= next_cfg;
      ctl     <= next_ctl;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Control levels to the analog side, registered from the register bits.
  // Routes to channels that the variant lacks stay open whatever the
  // register holds, so a stray write cannot close a switch to a missing pin.
  always_comb begin
    next_cfg_out.single_shot =
      cfg[lcr_pkg::CFG_SINGLE_SHOT_BIT];
    next_cfg_out.terminal_to_drive_link =
      cfg[lcr_pkg::CFG_DRIVE_LINK_BIT];
    next_cfg_out.electrode_detach_comparator_enable =
      cfg[lcr_pkg::CFG_DETACH_CMP_BIT];
    next_routes[4] = ctl[lcr_pkg::CTL_FOOT_CH6_BIT]
      && (CHANNELS >= 6);
    next_routes[3] = ctl[lcr_pkg::CTL_LEFT_CH5_BIT]
      && (CHANNELS >= 6);
    next_routes[2] = ctl[lcr_pkg::CTL_RIGHT_CH7_BIT]
      && (CHANNELS >= 8);
    next_routes[1] = ctl[lcr_pkg::CTL_RIGHT_CH4_BIT];
    next_routes[0] = ctl[lcr_pkg::CTL_AMP_A_POWER_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_out <= '0;
      routes  <= 5'h00;
    end else begin
      cfg_out <= next_cfg_out;
      routes  <= next_routes;
    end
  end

  lcr_sel_decode u_sel (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (ctl[lcr_pkg::CTL_AMP_A_SEL_LSB +: lcr_pkg::CTL_AMP_A_SEL_W]),
    .onehot  (amp_a_onehot)
  );

  always_comb begin
    ctl_out.foot_lead_route_ch6         = routes[4];
    ctl_out.left_lead_route_ch5         = routes[3];
    ctl_out.right_lead_route_ch7        = routes[2];
    ctl_out.right_lead_route_ch4        = routes[1];
    ctl_out.terminal_amp_a_power        = routes[0];
    ctl_out.terminal_amp_a_input_onehot = amp_a_onehot;
  end

  sequence s_cfg_write;
    psel && penable && pready && pwrite && pstrb[0] && hit_cfg;
  endsequence

  sequence s_ctl_write;
    psel && penable && pready && pwrite && pstrb[0] && hit_ctl;
  endsequence

  a_single_shot_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> ##1 cfg_out.single_shot == $past(pwdata[3], 2))
    else $error("single-shot level does not follow write");

  a_drive_link_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> ##1 cfg_out.terminal_to_drive_link == $past(pwdata[2], 2))
    else $error("drive link level does not follow write");

  a_comparator_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> ##1
      cfg_out.electrode_detach_comparator_enable == $past(pwdata[1], 2))
    else $error("comparator enable does not follow write");

  a_ctl_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write ##1 (psel && !penable && !pwrite && hit_ctl)
      |=> prdata[7:0] == $past(pwdata[7:0], 2))
    else $error("control register readback mismatch");

  a_route_ch4: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1 ctl_out.right_lead_route_ch4 == $past(pwdata[4], 2))
    else $error("channel 4 route does not follow write");

  a_route_ch6: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1
      ctl_out.foot_lead_route_ch6 == ($past(pwdata[7], 2) && CHANNELS >= 6))
    else $error("channel 6 route wrong");

  a_route_ch5: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1
      ctl_out.left_lead_route_ch5 == ($past(pwdata[6], 2) && CHANNELS >= 6))
    else $error("channel 5 route wrong");

  a_route_ch7: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1
      ctl_out.right_lead_route_ch7 == ($past(pwdata[5], 2) && CHANNELS >= 8))
    else $error("channel 7 route wrong");

  a_amp_a_power: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1 ctl_out.terminal_amp_a_power == $past(pwdata[3], 2))
    else $error("amplifier A power does not follow write");

  a_amp_a_onehot: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot(ctl_out.terminal_amp_a_input_onehot))
    else $error("amplifier A select not one-hot");

  a_amp_a_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctl_write |=> ##1
      ctl_out.terminal_amp_a_input_onehot[$past(pwdata[2:0], 2)])
    else $error("amplifier A select decode wrong");

  a_cfg_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_cfg) |-> prdata[7:4] == 4'h0)
    else $error("config upper bits not zero");

  // Reset levels are checked at the edge after reset is seen low, so that
  // they hold even when that first edge is the one that applied the reset.
  a_cfg_reset_value: assert property (
    @(posedge pclk) !presetn |=> cfg == lcr_pkg::CFG_RESET)
    else $error("config register left its reset value");

  a_ctl_reset_value: assert property (
    @(posedge pclk) !presetn |=> ctl == lcr_pkg::CTL_RESET)
    else $error("control register left its reset value");

  a_outs_reset_idle: assert property (
    @(posedge pclk)
    !presetn |=> cfg_out == '0 && routes == 5'h00 && amp_a_onehot == 8'h01)
    else $error("control levels not idle after reset");

  a_pready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stands longer than one cycle");

  a_pready_after_setup: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no ready in the cycle after setup");

  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !(hit_cfg || hit_ctl)) |-> pslverr)
    else $error("unmapped access answered without error");

  a_mapped_no_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && (hit_cfg || hit_ctl)) |-> !pslverr)
    else $error("mapped access answered with error");

  // A refused write, by address or by strobe, leaves both registers alone.
  a_unmapped_no_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && !(hit_cfg || hit_ctl))
      |=> $stable(cfg) && $stable(ctl))
    else $error("unmapped write changed a register");

  a_strobe_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && !pstrb[0])
      |=> $stable(cfg) && $stable(ctl))
    else $error("write without low strobe changed a register");

  a_prdata_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata))
    else $error("read data changed outside a setup");

  a_read_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite) |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above the low byte not zero");

  a_cfg_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_write ##1 (setup && !pwrite && hit_cfg)
      |=> prdata[7:0] == ($past(pwdata[7:0], 2) & lcr_pkg::CFG_WMASK))
    else $error("config register readback mismatch");

  // One check per select code: each stored code drives only its own switch.
  for (genvar k = 0; k < 8; k++) begin : g_sel_code
    a_sel_code_map: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctl[2:0] == 3'(k) |=> amp_a_onehot == 8'(1 << k))
      else $error("amplifier A select code drives the wrong input");
  end

endmodule

// ---- hw/lcr_pkg.sv ----
// Package with register map, field positions and carrier types for lead config.
package lcr_pkg;

  localparam logic [11:0] CFG_OFFSET      = 12'h05C;
  localparam logic [11:0] CTL_OFFSET      = 12'h060;
  localparam logic [7:0]  CFG_INDEX       = 8'h17;
  localparam logic [7:0]  CTL_INDEX       = 8'h18;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  CTL_RESET       = 8'h00;

  localparam int CFG_SINGLE_SHOT_BIT  = 3;
  localparam int CFG_DRIVE_LINK_BIT   = 2;
  localparam int CFG_DETACH_CMP_BIT   = 1;
  localparam int CTL_FOOT_CH6_BIT     = 7;
  localparam int CTL_LEFT_CH5_BIT     = 6;
  localparam int CTL_RIGHT_CH7_BIT    = 5;
  localparam int CTL_RIGHT_CH4_BIT    = 4;
  localparam int CTL_AMP_A_POWER_BIT  = 3;
  localparam int CTL_AMP_A_SEL_LSB    = 0;
  localparam int CTL_AMP_A_SEL_W      = 3;

  // Writable bits of the configuration register that this block owns.
  localparam logic [7:0] CFG_WMASK    = 8'h0F;

  // Channel count of the variant; lead routes to absent channels stay off.
  localparam int CHANNELS_DEFAULT     = 8;

  typedef struct packed {
    logic       single_shot;
    logic       terminal_to_drive_link;
    logic       electrode_detach_comparator_enable;
  } lcr_cfg_out_t;

  typedef struct packed {
    logic       foot_lead_route_ch6;
    logic       left_lead_route_ch5;
    logic       right_lead_route_ch7;
    logic       right_lead_route_ch4;
    logic       terminal_amp_a_power;
    logic [7:0] terminal_amp_a_input_onehot;
  } lcr_ctl_out_t;

  typedef enum logic [1:0] {
    LCR_IDLE   = 2'b00,
    LCR_ACCESS = 2'b01
  } lcr_state_t;

endpackage

// ---- hw/lcr_sel_decode.sv ----
// Decoder from the amplifier A input select code to one-hot switch levels.
`timescale 1ns/1ps
module lcr_sel_decode (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] sel,
  output logic      [7:0] onehot
);

  logic [7:0] next_onehot;

  // Bit 2k is channel k+1 positive, bit 2k+1 channel k+1 negative.
  always_comb begin
    next_onehot = 8'h00;
    next_onehot[sel] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onehot <= 8'h01;
    end else begin
      onehot <= next_onehot;
    end
  end

endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the lead configuration register bank.
`timescale 1ns/1ps
module tb;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  lcr_pkg::lcr_cfg_out_t cfg_out;
  lcr_pkg::lcr_ctl_out_t ctl_out;
  logic [31:0]           rd;
  logic [31:0]           d;
  logic                  err;
  int                    mismatches;
  int                    comparisons;
  int                    cyc;
  int                    seed;
  int                    cfg_m;
  int                    ctl_m;

  lcr_regs #(.CHANNELS(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_out(cfg_out), .ctl_out(ctl_out)
  );

  always #5 pclk = ~pclk;

  task report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung handshake ends the run through the common report.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // A write and then a read of the same word, the read setup following the
  // write's access edge at once.
  task wr_rd(input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'b1;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 1'b0;
    pwrite  <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs settle one edge after the write edge.
  task chk_outs;
    repeat (3) @(posedge pclk);
    chk({29'h0, cfg_out}, {29'h0, cfg_m[3:1]}, "cfg_out");
    chk({19'h0, ctl_out}, {19'h0, ctl_m[7:3], 8'h01 << ctl_m[2:0]},
        "ctl_out");
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hF; seed = 47; cyc = 0;
    cfg_m = 0; ctl_m = 0; mismatches = 0; comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_outs;
    apb(1'b0, lcr_pkg::CFG_OFFSET, 32'h0, 4'hF);
    chk(rd, 32'h0, "cfg reset");
    apb(1'b0, lcr_pkg::CTL_OFFSET, 32'h0, 4'hF);
    chk(rd, 32'h0, "ctl reset");
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      d[3:0] = i[3:0];
      cfg_m = int'(d[3:0]);
      if (i[0]) begin
        wr_rd(lcr_pkg::CFG_OFFSET, d);
      end else begin
        apb(1'b1, lcr_pkg::CFG_OFFSET, d, 4'hF);
        apb(1'b0, lcr_pkg::CFG_OFFSET, 32'h0, 4'hF);
      end
      chk(rd, 32'(cfg_m), "cfg read");
      chk_outs;
    end
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      d[2:0] = i[2:0];
      if (i > 7) d[7:3] = (i == 8) ? 5'h1F : 5'h00;
      ctl_m = int'(d[7:0]);
      if (i[0]) begin
        wr_rd(lcr_pkg::CTL_OFFSET, d);
      end else begin
        apb(1'b1, lcr_pkg::CTL_OFFSET, d, 4'hF);
        apb(1'b0, lcr_pkg::CTL_OFFSET, 32'h0, 4'hF);
      end
      chk(rd, 32'(ctl_m), "ctl read");
      chk_outs;
    end
    // A write with the low byte strobe off must leave the register alone.
    apb(1'b1, lcr_pkg::CTL_OFFSET, ~32'(ctl_m), 4'hE);
    chk({31'h0, err}, 32'h0, "strobe err");
    apb(1'b0, lcr_pkg::CTL_OFFSET, 32'h0, 4'hF);
    chk(rd, 32'(ctl_m), "strobe read");
    apb(1'b1, 12'h064, 32'hFF, 4'hF);
    chk({31'h0, err}, 32'h1, "unmapped wr");
    apb(1'b0, 12'h064, 32'h0, 4'hF);
    chk({31'h0, err}, 32'h1, "unmapped rd");
    chk(rd, 32'h0, "unmapped data");
    chk_outs;
    // Reset in mid-run returns every control to its idle level.
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    cfg_m = 0;
    ctl_m = 0;
    chk_outs;
    report_and_stop;
  end
endmodule
